// File: hdl/octal_dac_serial_write_port.sv
// Serial write port, input and converter registers, reference selection
`timescale 1ns/10ps
module octal_dac_serial_write_port #(
    parameter int CHANNELS  = dac_serial_pkg::CHANNELS,
    parameter int CODE_BITS = dac_serial_pkg::CODE_BITS
) (
    input  wire logic                          clk,
    input  wire logic                          rstn,
    input  wire logic                          serial_clock,
    input  wire logic                          frame_sync_n,
    input  wire logic                          serial_data_in,
    input  wire logic                          load_dac_n,
    output logic [CHANNELS-1:0][CODE_BITS-1:0] dac_code,
    output logic [1:0]                         ref_buffer_select,
    output logic [1:0]                         ref_supply_select,
    output logic                               input_buffers_on
);
    // ---------------- Link domain (serial_clock falling edge) ----------------
    logic [dac_serial_pkg::WORD_BITS-1:0] shift_reg;
    logic [dac_serial_pkg::CNT_BITS-1:0]  bit_cnt_reg;
    logic [dac_serial_pkg::WORD_BITS-1:0] word_hold_reg;
    logic                                 word_tog_reg;

    // Frame select high clears the count asynchronously, so an early rise
    // drops the partial word even though the serial clock may stop.
    always_ff @(negedge serial_clock or posedge frame_sync_n) begin
        if (frame_sync_n) begin
            bit_cnt_reg <= '0;
        end else if (bit_cnt_reg == 5'(dac_serial_pkg::WORD_BITS - 1)) begin
            bit_cnt_reg <= '0;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    always_ff @(negedge serial_clock or negedge rstn) begin
        if (!rstn) begin
            shift_reg <= '0;
        end else if (!frame_sync_n) begin
            shift_reg <= {shift_reg[dac_serial_pkg::WORD_BITS-2:0], serial_data_in};
        end
    end

    // Complete word is captured and flagged by toggle on the 16th edge
    always_ff @(negedge serial_clock or negedge rstn) begin
        if (!rstn) begin
            word_hold_reg <= '0;
            word_tog_reg  <= 1'b0;
        end else if (!frame_sync_n && bit_cnt_reg == 5'(dac_serial_pkg::WORD_BITS - 1)) begin
            word_hold_reg <= {shift_reg[dac_serial_pkg::WORD_BITS-2:0], serial_data_in};
            word_tog_reg  <= ~word_tog_reg;
        end
    end

    // ---------------- System domain ----------------
    logic [2:0] tog_sync_reg;
    logic [2:0] fs_sync_reg;
    logic [2:0] ld_sync_reg;
    logic       fs_level_reg;
    logic       ld_level_reg;
    logic       word_seen_reg;

    // Hold register is stable for a full frame after the toggle moves,
    // far longer than the three-stage crossing.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tog_sync_reg <= '0;
            fs_sync_reg  <= 3'h7;
            ld_sync_reg  <= 3'h7;
        end else begin
            tog_sync_reg <= {tog_sync_reg[1:0], word_tog_reg};
            fs_sync_reg  <= {fs_sync_reg[1:0], frame_sync_n};
            ld_sync_reg  <= {ld_sync_reg[1:0], load_dac_n};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fs_level_reg  <= 1'b1;
            ld_level_reg  <= 1'b1;
            word_seen_reg <= 1'b0;
        end else begin
            if (fs_sync_reg[2] == fs_sync_reg[1]) begin
                fs_level_reg <= fs_sync_reg[2];
            end
            if (ld_sync_reg[2] == ld_sync_reg[1]) begin
                ld_level_reg <= ld_sync_reg[2];
            end
            if (tog_sync_reg[2] == tog_sync_reg[1]) begin
                word_seen_reg <= tog_sync_reg[2];
            end
        end
    end

    wire  word_event = (tog_sync_reg[2] == tog_sync_reg[1]) && (tog_sync_reg[2] != word_seen_reg);
    dac_serial_pkg::serial_word_t rx_word;
    assign rx_word = dac_serial_pkg::serial_word_t'(word_hold_reg);

    // Buffers on from frame start until the word lands or the frame ends
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            input_buffers_on <= 1'b0;
        end else if (fs_level_reg && fs_sync_reg[2] == fs_sync_reg[1] && !fs_sync_reg[2]) begin
            input_buffers_on <= 1'b1;
        end else if (fs_level_reg || word_event) begin
            input_buffers_on <= 1'b0;
        end
    end

    logic [CHANNELS-1:0][CODE_BITS-1:0] input_reg;
    logic [CHANNELS-1:0]                fresh_reg;

    generate
        for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
            wire hit = word_event && !rx_word.is_ctrl && rx_word.channel == 3'(ch);
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    input_reg[ch] <= dac_serial_pkg::ZERO_CODE;
                end else if (hit) begin
                    input_reg[ch] <= rx_word.code[CODE_BITS-1:0];
                end
            end
            // New data flag; a fresh write wins over the clear by a load
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    fresh_reg[ch] <= 1'b0;
                end else if (hit) begin
                    fresh_reg[ch] <= 1'b1;
                end else if (!ld_level_reg) begin
                    fresh_reg[ch] <= 1'b0;
                end
            end
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    dac_code[ch] <= dac_serial_pkg::ZERO_CODE;
                end else if (!ld_level_reg && fresh_reg[ch]) begin
                    dac_code[ch] <= input_reg[ch];
                end
            end
        end
    endgenerate

    // Per quad: bit 0 channels A-D, bit 1 channels E-H; supply overrides buffer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ref_buffer_select <= 2'h0;
            ref_supply_select <= 2'h0;
        end else if (word_event && rx_word.is_ctrl) begin
            ref_buffer_select <= rx_word.code[dac_serial_pkg::BUF_LSB +: 2];
            ref_supply_select <= rx_word.code[dac_serial_pkg::SUP_LSB +: 2];
        end
    end
endmodule : octal_dac_serial_write_port

// File: include/dac_serial_pkg.sv
// Shared constants and types for the octal converter serial write port
// Behaviour
// - While load_dac_n is low the converter registers take the contents of the input registers.
// - A low pulse updates every converter register with new input data at once, and a held low level updates continuously.
// - A falling frame_sync_n wakes the clock and data buffers and arms the shift register for a new word.
// - After frame_sync_n falls the controller presents bits and the device captures one on each of the next 16 falling serial clock edges.
// - If frame_sync_n rises before the 16th falling edge the frame is dropped and no input, converter or reference select register changes.
// - A 16-bit input shift register samples serial_data_in on every falling serial clock edge of an active frame.
// - After each write cycle the serial clock and data buffers stay powered down until the next frame select falling edge.
// - Each reference input, one for channels A to D and one for E to H, is buffered, unbuffered or the supply per its select bits.
package dac_serial_pkg;
    localparam int WORD_BITS     = 16;
    localparam int CHANNELS      = 8;
    localparam int CODE_BITS     = 12;
    localparam int CNT_BITS      = 5;
    localparam int MAX_SCLK_MHZ  = 30;
    // Word layout: [15] control flag, [14:12] channel, [11:0] code
    localparam int CTRL_BIT      = 15;
    localparam int CH_MSB        = 14;
    localparam int CH_LSB        = 12;
    localparam int CODE_MSB      = 11;
    // Control word: [3:2] buffer select per quad, [1:0] supply select per quad
    localparam int BUF_LSB       = 2;
    localparam int SUP_LSB       = 0;
    localparam logic [CODE_BITS-1:0] ZERO_CODE = 12'h000;

    typedef enum logic [1:0] {
        REF_UNBUFFERED,
        REF_BUFFERED,
        REF_SUPPLY
    } ref_mode_t;

    typedef struct packed {
        logic                 is_ctrl;
        logic [2:0]           channel;
        logic [CODE_BITS-1:0] code;
    } serial_word_t;
endpackage : dac_serial_pkg

// File: dv/octal_dac_serial_write_port_assertions.sv
// Port checks for the serial write port
`timescale 1ns/10ps
module octal_dac_serial_write_port_assertions #(
    parameter int CHANNELS  = dac_serial_pkg::CHANNELS,
    parameter int CODE_BITS = dac_serial_pkg::CODE_BITS
) (
    input wire logic                          clk,
    input wire logic                          rstn,
    input wire logic                          serial_clock,
    input wire logic                          frame_sync_n,
    input wire logic                          serial_data_in,
    input wire logic                          load_dac_n,
    input wire logic [CHANNELS-1:0][CODE_BITS-1:0] dac_code,
    input wire logic [1:0]                    ref_buffer_select,
    input wire logic [1:0]                    ref_supply_select,
    input wire logic                          input_buffers_on
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Long enough for the last word to land
    sequence idle_s;
        frame_sync_n [*8];
    endsequence
    a_frame_wakes: assert property ($fell(frame_sync_n) |-> ##[1:6] input_buffers_on)
        else $error("buffers not woken by frame");
    a_wake_in_frame: assert property ($rose(input_buffers_on) |-> !frame_sync_n)
        else $error("buffers woke outside a frame");
    a_idle_sleep: assert property (idle_s |-> !input_buffers_on)
        else $error("buffers awake while idle");
    a_codes_hold: assert property (load_dac_n [*6] |-> $stable(dac_code))
        else $error("codes moved without load");
    a_load_cause: assert property ($changed(dac_code) |->
        !$past(load_dac_n, 2) || !$past(load_dac_n, 3) || !$past(load_dac_n, 4))
        else $error("codes moved with load high");
    a_idle_codes: assert property ((idle_s and !load_dac_n [*8]) |-> $stable(dac_code))
        else $error("codes moved while idle");
    a_idle_refs: assert property (idle_s |-> $stable({ref_buffer_select, ref_supply_select}))
        else $error("reference selects moved while idle");
    a_reset_zero: assert property ($rose(rstn) |-> dac_code == '0 && ref_buffer_select == 2'h0)
        else $error("outputs not zero after reset");
endmodule : octal_dac_serial_write_port_assertions

bind octal_dac_serial_write_port octal_dac_serial_write_port_assertions #(
    .CHANNELS(CHANNELS), .CODE_BITS(CODE_BITS)) checker_inst (.clk(clk), .rstn(rstn),
    .serial_clock(serial_clock), .frame_sync_n(frame_sync_n), .serial_data_in(serial_data_in),
    .load_dac_n(load_dac_n), .dac_code(dac_code), .ref_buffer_select(ref_buffer_select),
    .ref_supply_select(ref_supply_select), .input_buffers_on(input_buffers_on));

// File: dv/serial_master_model.sv
// Serial controller model that drives write frames
`timescale 1ns/10ps
module serial_master_model (
    output logic serial_clock,
    output logic frame_sync_n,
    output logic serial_data_in
);
    initial begin
        serial_clock = 1'b1;
        frame_sync_n = 1'b1;
        serial_data_in = 1'b0;
    end
    // 48 ns period keeps well under 30 MHz
    task automatic send(input logic [15:0] word, input int nbits);
        frame_sync_n = 1'b0;
        for (int i = 15; i > 15 - nbits; i--) begin
            #13 serial_data_in = word[i];
            #11 serial_clock = 1'b0;
            #24 serial_clock = 1'b1;
        end
        frame_sync_n = 1'b1;
        // Released line must not look like valid data
        serial_data_in = ~serial_data_in;
        #300;
    endtask : send
endmodule : serial_master_model

// File: dv/octal_dac_serial_write_port_tb.sv
// Self-checking bench for the serial write port
`timescale 1ns/10ps
module octal_dac_serial_write_port_tb;
    logic clk, rstn, load_dac_n;
    wire logic serial_clock, frame_sync_n, serial_data_in;
    logic [dac_serial_pkg::CHANNELS-1:0][dac_serial_pkg::CODE_BITS-1:0] dac_code;
    logic [1:0] ref_buffer_select, ref_supply_select;
    logic input_buffers_on;
    int err_count = 0, checked = 0, buf_m = 0, sup_m = 0;
    int in_m[8] = '{default: 0}, dac_m[8] = '{default: 0};
    octal_dac_serial_write_port uut (.clk(clk), .rstn(rstn), .serial_clock(serial_clock),
        .frame_sync_n(frame_sync_n), .serial_data_in(serial_data_in), .load_dac_n(load_dac_n),
        .dac_code(dac_code), .ref_buffer_select(ref_buffer_select),
        .ref_supply_select(ref_supply_select), .input_buffers_on(input_buffers_on));
    serial_master_model master (.serial_clock(serial_clock), .frame_sync_n(frame_sync_n),
        .serial_data_in(serial_data_in));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic cmp_codes();
        for (int i = 0; i < 8; i++) begin
            checked++;
            if (dac_code[i] !== 12'(dac_m[i])) begin
                err_count++;
                $display("mismatch dac_code[%0d] exp %h got %h", i, 12'(dac_m[i]), dac_code[i]);
            end
        end
    endtask : cmp_codes
    task automatic cmp_refs();
        checked++;
        if ({ref_buffer_select, ref_supply_select} !== {2'(buf_m), 2'(sup_m)}) begin
            err_count++;
            $display("mismatch refs exp %h got %h", {2'(buf_m), 2'(sup_m)}, {ref_buffer_select, ref_supply_select});
        end
    endtask : cmp_refs
    task automatic write(input logic [15:0] w);
        master.send(w, 16);
        if (w[15]) begin
            buf_m = w[3:2];
            sup_m = w[1:0];
        end else
            in_m[w[14:12]] = w[11:0];
        if (!load_dac_n) dac_m = in_m;
    endtask : write
    task automatic test_done();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done
    initial begin
        #200000 err_count++;
        test_done();
    end
    initial begin
        void'($urandom(32'ha35f6126));
        rstn = 1'b0;
        load_dac_n = 1'b1;
        repeat (2) @(posedge clk);
        #2 rstn = 1'b1;
        repeat (4) @(posedge clk);
        cmp_codes();
        cmp_refs();
        $display("test reset done");
        for (int c = 0; c < 8; c++) write({1'b0, 3'(c), 12'($urandom)});
        cmp_codes();
        @(posedge clk) #2 load_dac_n = 1'b0;
        repeat (6) @(posedge clk);
        #2 load_dac_n = 1'b1;
        repeat (8) @(posedge clk);
        dac_m = in_m;
        cmp_codes();
        $display("test load pulse done");
        @(posedge clk) #2 load_dac_n = 1'b0;
        for (int k = 0; k < 6; k++) begin
            write({1'b0, 3'($urandom), 12'($urandom)});
            cmp_codes();
        end
        master.send(16'h7fff, 10);
        cmp_codes();
        $display("test held load and abort done");
        for (int k = 0; k < 16; k++) begin
            write({1'b1, 11'h000, 4'(k)});
            cmp_refs();
        end
        $display("test reference select done");
        test_done();
    end
endmodule : octal_dac_serial_write_port_tb
